// >>> logic/psv_supervisor.sv
// module: position error supervisor top with register port
`timescale 1ns/1ps
module psv_supervisor (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [31:0] reg_rdata_o,
   input wire logic ref_pulse_i,
   input wire logic ref_dir_i,
   input wire logic fb_pulse_i,
   input wire logic fb_dir_i,
   input wire logic [15:0] motor_speed_i,
   output logic motor_stop_o,
   output logic speed_clamp_en_o,
   output logic [13:0] speed_clamp_o,
   output logic tuningless_en_o,
   output logic [3:0] tuningless_rigidity_o,
   output logic [3:0] tuningless_load_o,
   output logic irq_o
);
   // ************************************************************
   // declarations
   // ************************************************************
   psv_pkg::psv_state_t state_reg; // registered state
   psv_pkg::psv_state_t state_next; // next state
   psv_err_if err_bus (); // error count carrier
   logic cnt_clr; // clear the error counter
   logic [psv_pkg::PSV_EV_N-1:0] events; // one-cycle events
   logic [psv_pkg::PSV_EV_N-1:0] irq_status; // sticky status
   logic [psv_pkg::PSV_EV_N-1:0] irq_enable; // enable mask
   logic irq_clr_we; // clear register write
   logic irq_en_we; // enable register write
   logic ctrl_we; // control register write
   logic son_rise; // servo power switched on
   logic pos_mode; // position control active
   logic [15:0] gain_sel; // gain in use
   logic [63:0] exp_num; // expected error numerator
   logic [63:0] exp_den; // expected error denominator
   logic [63:0] exp_quot; // expected error quotient
   logic [36:0] warn_prod; // level times percent
   logic [31:0] warn_thr; // warning threshold
   logic alarm_clr; // explicit alarm clear

   // ************************************************************
   // submodules
   // ************************************************************
   // error counter, cleared on request or outside position control
   psv_err_cnt #(
      .WIDTH(32)
   ) u_cnt (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .ref_pulse_i(ref_pulse_i),
      .ref_dir_i(ref_dir_i),
      .fb_pulse_i(fb_pulse_i),
      .fb_dir_i(fb_dir_i),
      .clr_i(cnt_clr),
      .cnt(err_bus.cnt)
   );

   // event status and interrupt
   psv_irq #(
      .N(psv_pkg::PSV_EV_N)
   ) u_irq (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .event_i(events),
      .clr_we_i(irq_clr_we),
      .en_we_i(irq_en_we),
      .wdata_i(reg_wdata_i[psv_pkg::PSV_EV_N-1:0]),
      .status_o(irq_status),
      .enable_o(irq_enable),
      .irq_o(irq_o)
   );

   // ************************************************************
   // decode and derived terms
   // ************************************************************
   // write strobes for the side registers
   always_comb begin
      ctrl_we = 1'b0;
      irq_clr_we = 1'b0;
      irq_en_we = 1'b0;
      if (reg_we_i && reg_addr_i == psv_pkg::PSV_CTRL_OFS) begin
         ctrl_we = 1'b1;
      end else if (reg_we_i && reg_addr_i == psv_pkg::PSV_IRQ_CLR_OFS) begin
         irq_clr_we = 1'b1;
      end else if (reg_we_i && reg_addr_i == psv_pkg::PSV_IRQ_EN_OFS) begin
         irq_en_we = 1'b1;
      end
   end

   assign alarm_clr = ctrl_we & reg_wdata_i[psv_pkg::PSV_CTRL_ACLR_BIT];
   assign pos_mode = (state_reg.mode == psv_pkg::PSV_MODE_POS);
   assign cnt_clr = (ctrl_we & reg_wdata_i[psv_pkg::PSV_CTRL_CCLR_BIT]) | ~pos_mode;
   assign son_rise = state_reg.servo_on & ~state_reg.son_prev;
   assign gain_sel = state_reg.mf_sel ? state_reg.mfgain : state_reg.pgain;

   // expected error = speed/(gain/10) * divs/(pitch/1000) * num/den
   assign exp_num = 64'(motor_speed_i) * psv_pkg::PSV_GAIN_SCALE * 64'(state_reg.divs)
                    * psv_pkg::PSV_PITCH_SCALE * 64'(state_reg.gnum);
   assign exp_den = 64'(gain_sel) * 64'(state_reg.pitch) * 64'(state_reg.gden);
   assign exp_quot = (exp_den == 64'h0) ? 64'h0 : exp_num / exp_den;

   // warning threshold = servo-on level * percent / 100
   assign warn_prod = 37'(state_reg.son_lvl) * 37'(state_reg.warn_pct);
   assign warn_thr = 32'(warn_prod / psv_pkg::PSV_PCT_FULL);

   // ************************************************************
   // supervision and register writes
   // ************************************************************
   always_comb begin
      state_next = state_reg;
      events = '0;
      state_next.son_prev = state_reg.servo_on;
      state_next.exp_err = (exp_quot[63:32] != 32'h0) ? 32'hFFFF_FFFF : exp_quot[31:0];
      // register writes, levels clipped into range
      if (reg_we_i) begin
         if (reg_addr_i == psv_pkg::PSV_CTRL_OFS) begin
            state_next.mode = psv_pkg::psv_mode_t'(reg_wdata_i[1:0]);
            state_next.servo_on = reg_wdata_i[psv_pkg::PSV_CTRL_SON_BIT];
            state_next.mf_sel = reg_wdata_i[psv_pkg::PSV_CTRL_MF_BIT];
            if (reg_wdata_i[psv_pkg::PSV_CTRL_RESTART_BIT]) begin
               state_next.tl_act = state_reg.tl_cfg[0];
            end
         end else if (reg_addr_i == psv_pkg::PSV_ERR_LVL_OFS) begin
            state_next.err_lvl = psv_pkg::psv_clip_lvl(reg_wdata_i);
         end else if (reg_addr_i == psv_pkg::PSV_SON_LVL_OFS) begin
            state_next.son_lvl = psv_pkg::psv_clip_lvl(reg_wdata_i);
         end else if (reg_addr_i == psv_pkg::PSV_WARN_OFS) begin
            if (reg_wdata_i > 32'(psv_pkg::PSV_PCT_MAX)) begin
               state_next.warn_pct = psv_pkg::PSV_PCT_MAX;
            end else if (reg_wdata_i < 32'(psv_pkg::PSV_PCT_MIN)) begin
               state_next.warn_pct = psv_pkg::PSV_PCT_MIN;
            end else begin
               state_next.warn_pct = reg_wdata_i[6:0];
            end
         end else if (reg_addr_i == psv_pkg::PSV_CLAMP_OFS) begin
            if (reg_wdata_i > 32'(psv_pkg::PSV_CLAMP_MAX)) begin
               state_next.clamp = psv_pkg::PSV_CLAMP_MAX;
            end else begin
               state_next.clamp = reg_wdata_i[13:0];
            end
         end else if (reg_addr_i == psv_pkg::PSV_PGAIN_OFS) begin
            state_next.pgain = reg_wdata_i[15:0];
         end else if (reg_addr_i == psv_pkg::PSV_MFGAIN_OFS) begin
            state_next.mfgain = reg_wdata_i[15:0];
         end else if (reg_addr_i == psv_pkg::PSV_GNUM_OFS) begin
            state_next.gnum = reg_wdata_i[15:0];
         end else if (reg_addr_i == psv_pkg::PSV_GDEN_OFS) begin
            state_next.gden = reg_wdata_i[15:0];
         end else if (reg_addr_i == psv_pkg::PSV_TL_OFS) begin
            state_next.tl_cfg = reg_wdata_i[15:0];
         end else if (reg_addr_i == psv_pkg::PSV_DIVS_OFS) begin
            state_next.divs = reg_wdata_i[15:0];
         end else if (reg_addr_i == psv_pkg::PSV_PITCH_OFS) begin
            state_next.pitch = reg_wdata_i[15:0];
         end
      end
      // servo power on: check held error, start draining residue
      if (son_rise && pos_mode) begin
         if (psv_pkg::psv_exceeds(err_bus.mag, state_reg.son_lvl)) begin
            events[psv_pkg::PSV_EV_SON] = 1'b1;
         end
         if (err_bus.mag > warn_thr) begin
            events[psv_pkg::PSV_EV_WARN] = 1'b1;
         end
         state_next.clamp_act = ~err_bus.zero;
      end else if (err_bus.zero || !state_reg.servo_on || !pos_mode) begin
         state_next.clamp_act = 1'b0;
      end
      // running supervision in position control only
      if (pos_mode && state_reg.servo_on && !son_rise) begin
         if (psv_pkg::psv_exceeds(err_bus.mag, state_reg.err_lvl)) begin
            events[psv_pkg::PSV_EV_ERR] = 1'b1;
            if (state_reg.clamp_act && ref_pulse_i) begin
               events[psv_pkg::PSV_EV_CLAMP] = 1'b1;
            end
         end
      end
      // alarm latches, a new alarm wins over the clear
      if (alarm_clr) begin
         state_next.alarm = '0;
      end
      state_next.alarm = state_next.alarm | events[2:0];
      // read data, valid in the cycle after the strobe
      state_next.rdata = '0;
      if (reg_re_i) begin
         if (reg_addr_i == psv_pkg::PSV_CTRL_OFS) begin
            state_next.rdata = {28'h0, state_reg.mf_sel, state_reg.servo_on, state_reg.mode};
         end else if (reg_addr_i == psv_pkg::PSV_ERR_LVL_OFS) begin
            state_next.rdata = 32'(state_reg.err_lvl);
         end else if (reg_addr_i == psv_pkg::PSV_SON_LVL_OFS) begin
            state_next.rdata = 32'(state_reg.son_lvl);
         end else if (reg_addr_i == psv_pkg::PSV_WARN_OFS) begin
            state_next.rdata = 32'(state_reg.warn_pct);
         end else if (reg_addr_i == psv_pkg::PSV_CLAMP_OFS) begin
            state_next.rdata = 32'(state_reg.clamp);
         end else if (reg_addr_i == psv_pkg::PSV_PGAIN_OFS) begin
            state_next.rdata = 32'(state_reg.pgain);
         end else if (reg_addr_i == psv_pkg::PSV_MFGAIN_OFS) begin
            state_next.rdata = 32'(state_reg.mfgain);
         end else if (reg_addr_i == psv_pkg::PSV_GNUM_OFS) begin
            state_next.rdata = 32'(state_reg.gnum);
         end else if (reg_addr_i == psv_pkg::PSV_GDEN_OFS) begin
            state_next.rdata = 32'(state_reg.gden);
         end else if (reg_addr_i == psv_pkg::PSV_TL_OFS) begin
            state_next.rdata = 32'(state_reg.tl_cfg);
         end else if (reg_addr_i == psv_pkg::PSV_DIVS_OFS) begin
            state_next.rdata = 32'(state_reg.divs);
         end else if (reg_addr_i == psv_pkg::PSV_PITCH_OFS) begin
            state_next.rdata = 32'(state_reg.pitch);
         end else if (reg_addr_i == psv_pkg::PSV_STAT_OFS) begin
            state_next.rdata = {26'h0, state_reg.tl_act, state_reg.clamp_act, motor_stop_o,
                                state_reg.alarm};
         end else if (reg_addr_i == psv_pkg::PSV_ERR_OFS) begin
            state_next.rdata = err_bus.err;
         end else if (reg_addr_i == psv_pkg::PSV_EXP_OFS) begin
            state_next.rdata = state_reg.exp_err;
         end else if (reg_addr_i == psv_pkg::PSV_IRQ_STAT_OFS) begin
            state_next.rdata = 32'(irq_status);
         end else if (reg_addr_i == psv_pkg::PSV_IRQ_EN_OFS) begin
            state_next.rdata = 32'(irq_enable);
         end
      end
   end

   // register the state, documented defaults on reset
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state_reg <= '0;
         state_reg.err_lvl <= psv_pkg::PSV_LVL_RST;
         state_reg.son_lvl <= psv_pkg::PSV_LVL_RST;
         state_reg.warn_pct <= psv_pkg::PSV_PCT_RST;
         state_reg.clamp <= psv_pkg::PSV_CLAMP_RST;
         state_reg.pgain <= psv_pkg::PSV_GAIN_RST;
         state_reg.mfgain <= psv_pkg::PSV_GAIN_RST;
         state_reg.gnum <= psv_pkg::PSV_GEAR_RST;
         state_reg.gden <= psv_pkg::PSV_GEAR_RST;
         state_reg.tl_cfg <= psv_pkg::PSV_TL_RST;
         state_reg.tl_act <= 1'b1;
         state_reg.divs <= psv_pkg::PSV_DIVS_RST;
         state_reg.pitch <= psv_pkg::PSV_PITCH_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign motor_stop_o = (|state_reg.alarm) | ~state_reg.servo_on;
   assign speed_clamp_en_o = state_reg.clamp_act;
   assign speed_clamp_o = state_reg.clamp;
   assign tuningless_en_o = state_reg.tl_act;
   assign tuningless_rigidity_o = state_reg.tl_cfg[11:8];
   assign tuningless_load_o = state_reg.tl_cfg[15:12];
   assign reg_rdata_o = state_reg.rdata;
endmodule : psv_supervisor

// >>> logic/psv_pkg.sv
// package: constants, types and helpers of the position error supervisor
package psv_pkg;
   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] PSV_CTRL_OFS = 8'h00; // mode, servo on, pulses
   localparam logic [7:0] PSV_ERR_LVL_OFS = 8'h04; // error_alarm_level
   localparam logic [7:0] PSV_SON_LVL_OFS = 8'h08; // servo_on_error_alarm_level
   localparam logic [7:0] PSV_WARN_OFS = 8'h0C; // servo_on_error_warning_pct
   localparam logic [7:0] PSV_CLAMP_OFS = 8'h10; // servo_on_speed_clamp
   localparam logic [7:0] PSV_PGAIN_OFS = 8'h14; // position_loop_gain
   localparam logic [7:0] PSV_MFGAIN_OFS = 8'h18; // model_following_gain
   localparam logic [7:0] PSV_GNUM_OFS = 8'h1C; // gear_ratio_numerator
   localparam logic [7:0] PSV_GDEN_OFS = 8'h20; // gear_ratio_denominator
   localparam logic [7:0] PSV_TL_OFS = 8'h24; // tuningless_config
   localparam logic [7:0] PSV_DIVS_OFS = 8'h28; // scale divisions
   localparam logic [7:0] PSV_PITCH_OFS = 8'h2C; // scale pitch in um
   localparam logic [7:0] PSV_STAT_OFS = 8'h30; // live status, read only
   localparam logic [7:0] PSV_ERR_OFS = 8'h34; // signed error count, read only
   localparam logic [7:0] PSV_EXP_OFS = 8'h38; // expected steady error, read only
   localparam logic [7:0] PSV_IRQ_STAT_OFS = 8'h3C; // sticky events, read only
   localparam logic [7:0] PSV_IRQ_CLR_OFS = 8'h40; // write one to clear
   localparam logic [7:0] PSV_IRQ_EN_OFS = 8'h44; // interrupt enable
   // ************************************************************
   // control bit positions and event bits
   // ************************************************************
   localparam int PSV_CTRL_SON_BIT = 2;
   localparam int PSV_CTRL_MF_BIT = 3;
   localparam int PSV_CTRL_RESTART_BIT = 4;
   localparam int PSV_CTRL_ACLR_BIT = 5;
   localparam int PSV_CTRL_CCLR_BIT = 6;
   localparam int PSV_EV_ERR = 0; // error overflow
   localparam int PSV_EV_SON = 1; // servo-on overflow
   localparam int PSV_EV_CLAMP = 2; // speed clamp overflow
   localparam int PSV_EV_WARN = 3; // servo-on warning
   localparam int PSV_EV_N = 4;
   // ************************************************************
   // reset values and ranges
   // ************************************************************
   localparam logic [29:0] PSV_LVL_MIN = 30'h0000_0001;
   localparam logic [29:0] PSV_LVL_MAX = 30'h3FFF_FFFF; // 1073741823
   localparam logic [29:0] PSV_LVL_RST = 30'h0050_0000; // 5242880
   localparam logic [6:0] PSV_PCT_MIN = 7'h0A;
   localparam logic [6:0] PSV_PCT_MAX = 7'h64;
   localparam logic [6:0] PSV_PCT_RST = 7'h64;
   localparam logic [13:0] PSV_CLAMP_MAX = 14'h2710; // 10000 mm/s
   localparam logic [13:0] PSV_CLAMP_RST = 14'h2710;
   localparam logic [15:0] PSV_GAIN_RST = 16'h0190; // 40.0/s in 0.1/s
   localparam logic [15:0] PSV_GEAR_RST = 16'h0001;
   localparam logic [15:0] PSV_DIVS_RST = 16'h0100;
   localparam logic [15:0] PSV_PITCH_RST = 16'h0014;
   localparam logic [15:0] PSV_TL_RST = 16'h0001; // tuning-less enabled
   localparam logic [63:0] PSV_GAIN_SCALE = 64'h0000_0000_0000_000A; // gain unit 0.1/s
   localparam logic [63:0] PSV_PITCH_SCALE = 64'h0000_0000_0000_03E8; // um per mm
   localparam logic [36:0] PSV_PCT_FULL = 37'h00_0000_0064;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      PSV_MODE_POS = 2'b00,
      PSV_MODE_SPEED = 2'b01,
      PSV_MODE_FORCE = 2'b10
   } psv_mode_t;

   typedef struct packed {
      psv_mode_t mode;
      logic servo_on;
      logic mf_sel;
      logic [29:0] err_lvl;
      logic [29:0] son_lvl;
      logic [6:0] warn_pct;
      logic [13:0] clamp;
      logic [15:0] pgain;
      logic [15:0] mfgain;
      logic [15:0] gnum;
      logic [15:0] gden;
      logic [15:0] tl_cfg;
      logic tl_act;
      logic [15:0] divs;
      logic [15:0] pitch;
      logic son_prev;
      logic clamp_act;
      logic [2:0] alarm;
      logic [31:0] exp_err;
      logic [31:0] rdata;
   } psv_state_t;

   // ************************************************************
   // helpers
   // ************************************************************
   // clip a written level into its legal range
   function automatic logic [29:0] psv_clip_lvl(input logic [31:0] v);
      if (v[31:30] != 2'b00) begin
         return PSV_LVL_MAX;
      end else if (v[29:0] < PSV_LVL_MIN) begin
         return PSV_LVL_MIN;
      end
      return v[29:0];
   endfunction : psv_clip_lvl

   // magnitude strictly above a level
   function automatic logic psv_exceeds(input logic [31:0] mag, input logic [29:0] lvl);
      return mag > {2'b00, lvl};
   endfunction : psv_exceeds
endpackage : psv_pkg

// >>> logic/psv_err_if.sv
// interface: error count from the counter to its users
`timescale 1ns/1ps
interface psv_err_if;
   logic signed [31:0] err; // reference minus feedback
   logic [31:0] mag; // magnitude of err
   logic zero; // counter holds no error
   modport cnt (output err, output mag, output zero);
   modport mon (input err, input mag, input zero);
endinterface : psv_err_if

// >>> logic/psv_err_cnt.sv
// module: signed position error counter
`timescale 1ns/1ps
module psv_err_cnt #(
   parameter int WIDTH = 32
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ref_pulse_i,
   input wire logic ref_dir_i,
   input wire logic fb_pulse_i,
   input wire logic fb_dir_i,
   input wire logic clr_i,
   psv_err_if.cnt cnt
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic signed [WIDTH-1:0] err;
   } psv_cnt_state_t;

   psv_cnt_state_t state_reg; // registered state
   psv_cnt_state_t state_next; // next state
   logic signed [WIDTH-1:0] step; // net step this cycle

   // net step: reference adds, feedback subtracts
   always_comb begin
      step = '0;
      if (ref_pulse_i) begin
         step = ref_dir_i ? step - 1 : step + 1;
      end
      if (fb_pulse_i) begin
         step = fb_dir_i ? step + 1 : step - 1;
      end
      state_next = state_reg;
      if (clr_i) begin
         state_next.err = '0;
      end else begin
         state_next.err = state_reg.err + step;
      end
   end

   // register the state
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs, magnitude for either direction
   assign cnt.err = 32'(state_reg.err);
   assign cnt.mag = state_reg.err[WIDTH-1] ? 32'(-state_reg.err) : 32'(state_reg.err);
   assign cnt.zero = (state_reg.err == '0);
endmodule : psv_err_cnt

// >>> logic/psv_irq.sv
// module: sticky event status, enable and level interrupt
`timescale 1ns/1ps
module psv_irq #(
   parameter int N = 4
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [N-1:0] event_i,
   input wire logic clr_we_i,
   input wire logic en_we_i,
   input wire logic [N-1:0] wdata_i,
   output logic [N-1:0] status_o,
   output logic [N-1:0] enable_o,
   output logic irq_o
);
   typedef struct packed {
      logic [N-1:0] status;
      logic [N-1:0] enable;
   } psv_irq_state_t;

   psv_irq_state_t state_reg; // registered state
   psv_irq_state_t state_next; // next state

   // set wins over a clear in the same cycle
   always_comb begin
      state_next = state_reg;
      if (clr_we_i) begin
         state_next.status = state_reg.status & ~wdata_i;
      end
      state_next.status = state_next.status | event_i;
      if (en_we_i) begin
         state_next.enable = wdata_i;
      end
   end

   // register the state
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign status_o = state_reg.status;
   assign enable_o = state_reg.enable;
   assign irq_o = |(state_reg.status & state_reg.enable);
endmodule : psv_irq

// >>> dv/psv_monitor.sv
// checker: port relations of the position error supervisor
`timescale 1ns/1ps
module psv_monitor (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic motor_stop_o,
   input wire logic speed_clamp_en_o,
   input wire logic [13:0] speed_clamp_o,
   input wire logic tuningless_en_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   logic son_wr; // control write with servo power on
   logic rs_wr; // control write with restart pulse
   assign son_wr = reg_we_i && reg_addr_i == 8'h00 && reg_wdata_i[2];
   assign rs_wr = reg_we_i && reg_addr_i == 8'h00 && reg_wdata_i[4];
   // servo power switched off by a control write
   sequence s_son_off;
      reg_we_i && reg_addr_i == 8'h00 && !reg_wdata_i[2];
   endsequence
   a_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
      else $error("read data outside answer cycle");
   a_reset_vals: assert property ($fell(srst_i) |-> tuningless_en_o && motor_stop_o)
      else $error("wrong state after reset");
   a_son_stop: assert property (s_son_off |=> motor_stop_o)
      else $error("motor runs with servo off");
   a_stop_release: assert property ($fell(motor_stop_o) |-> $past(son_wr))
      else $error("stop released without control write");
   a_clamp_start: assert property ($rose(speed_clamp_en_o) |-> $past(son_wr, 2))
      else $error("clamp raised outside servo-on");
   a_clamp_off: assert property (s_son_off |-> ##[1:2] !speed_clamp_en_o)
      else $error("clamp held with servo off");
   a_clamp_range: assert property (speed_clamp_o <= 14'h2710)
      else $error("clamp speed above range");
   a_irq_mask: assert property (reg_we_i && reg_addr_i == 8'h44 && reg_wdata_i[3:0] == 4'h0 |=> !irq_o)
      else $error("interrupt with all enables off");
   a_tl_restart: assert property ($changed(tuningless_en_o) |-> $past(rs_wr) || $past(rs_wr, 2))
      else $error("tuning-less changed without restart");
endmodule : psv_monitor

// >>> dv/psv_host_model.sv
// model: host controller sending reference pulses
`timescale 1ns/1ps
module psv_host_model (
   input wire logic clk_sys_i,
   output logic ref_pulse_o,
   output logic ref_dir_o
);
   initial begin
      ref_pulse_o = 1'b0;
      ref_dir_o = 1'b0;
   end
   // n pulses in one direction, gap idle cycles between them
   task automatic send(input int n, input logic dir, input int gap);
      repeat (n) begin
         @(posedge clk_sys_i);
         ref_pulse_o <= 1'b1;
         ref_dir_o <= dir;
         repeat (gap) begin
            @(posedge clk_sys_i);
            ref_pulse_o <= 1'b0;
         end
      end
      @(posedge clk_sys_i);
      ref_pulse_o <= 1'b0;
   endtask : send
endmodule : psv_host_model

// >>> dv/tb.sv
// testbench: registers, alarms and pulses of the supervisor
`timescale 1ns/1ps
module tb;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic fb_pulse_i = 1'b0;
   logic ref_pulse_i, ref_dir_i, motor_stop_o, clamp_en, tl_en, irq_o;
   logic [31:0] reg_rdata_o;
   logic [13:0] clamp;
   logic [3:0] tl_rig, tl_load;
   int n_mismatch = 0;
   int num_checks = 0;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} psv_row_t; // address, write, read-back
   psv_row_t rows[9] = '{'{8'h04, 32'h0, 32'h1}, '{8'h08, 32'hFFFFFFFF, 32'h3FFFFFFF}, '{8'h0C, 32'h5, 32'hA},
      '{8'h0C, 32'h65, 32'h64}, '{8'h10, 32'h3000, 32'h2710}, '{8'h10, 32'h0, 32'h0},
      '{8'h18, 32'h320, 32'h320}, '{8'h48, 32'h1234, 32'h0}, '{8'h40, 32'h1, 32'h0}};
   always #2.5 clk_sys_i = ~clk_sys_i;
   psv_host_model u_host (.clk_sys_i(clk_sys_i), .ref_pulse_o(ref_pulse_i), .ref_dir_o(ref_dir_i));
   psv_supervisor u_psv_supervisor (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
      .ref_pulse_i(ref_pulse_i), .ref_dir_i(ref_dir_i), .fb_pulse_i(fb_pulse_i), .fb_dir_i(1'b0),
      .motor_speed_i(16'h0064), .motor_stop_o(motor_stop_o), .speed_clamp_en_o(clamp_en),
      .speed_clamp_o(clamp), .tuningless_en_o(tl_en), .tuningless_rigidity_o(tl_rig),
      .tuningless_load_o(tl_load), .irq_o(irq_o));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one-cycle write strobe, then one settling cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_we_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_we_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask : wr
   // read strobe, data compared in the answer cycle
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys_i);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_re_i <= 1'b0;
      #1;
      chk(n, e, reg_rdata_o);
   endtask : rd
   // feedback pulses, forward motion
   task automatic fb(input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         fb_pulse_i <= 1'b1;
      end
      @(posedge clk_sys_i);
      fb_pulse_i <= 1'b0;
   endtask : fb
   task automatic summarize();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_mismatch++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd("row", rows[i].a, rows[i].e);
      end
      rd("exp", 8'h38, 32'h7D00);
      wr(8'h04, 32'hBB80);
      rd("lvl_margin", 8'h04, 32'hBB80);
      wr(8'h00, 32'h8);
      rd("exp_mf", 8'h38, 32'h3E80);
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      rd("son_lvl", 8'h08, 32'h500000);
      rd("warn", 8'h0C, 32'h64);
      wr(8'h24, 32'h3210);
      chk("tl", 32'h132, {tl_en, tl_load, tl_rig});
      wr(8'h00, 32'h10);
      chk("tl_rs", 32'h0, tl_en);
      wr(8'h04, 32'h4);
      wr(8'h44, 32'hF);
      wr(8'h00, 32'h5);
      u_host.send(6, 1'b0, 0);
      rd("spd_st", 8'h30, 32'h0);
      wr(8'h00, 32'h4);
      u_host.send(3, 1'b0, 2);
      fb(1);
      rd("err", 8'h34, 32'h2);
      u_host.send(3, 1'b0, 0);
      rd("ovf", 8'h30, 32'h9);
      chk("irq", 32'h1, irq_o);
      wr(8'h00, 32'h44);
      rd("latch", 8'h30, 32'h9);
      wr(8'h00, 32'h24);
      wr(8'h40, 32'hF);
      chk("irq_clr", 32'h0, irq_o);
      u_host.send(5, 1'b1, 0);
      rd("neg", 8'h34, 32'hFFFFFFFB);
      rd("neg_st", 8'h30, 32'h9);
      wr(8'h00, 32'h40);
      wr(8'h00, 32'h20);
      wr(8'h10, 32'h1F4);
      u_host.send(8, 1'b0, 0);
      wr(8'h08, 32'h8);
      wr(8'h04, 32'h14);
      wr(8'h00, 32'h4);
      rd("son_eq", 8'h30, 32'h10);
      chk("clamp", 32'h41F4, {17'h0, clamp_en, clamp});
      fb(8);
      rd("drain", 8'h30, 32'h0);
      wr(8'h00, 32'h0);
      u_host.send(8, 1'b0, 0);
      wr(8'h08, 32'h7);
      wr(8'h00, 32'h4);
      rd("son_ovf", 8'h30, 32'h1A);
      wr(8'h00, 32'h24);
      u_host.send(14, 1'b0, 0);
      rd("clamp_ovf", 8'h30, 32'h1D);
      rd("irq_st", 8'h3C, 32'hF);
      wr(8'h44, 32'h0);
      chk("irq_mask", 32'h0, irq_o);
      summarize();
   end
endmodule : tb
bind psv_supervisor psv_monitor u_psv_monitor (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
   .motor_stop_o(motor_stop_o), .speed_clamp_en_o(speed_clamp_en_o), .speed_clamp_o(speed_clamp_o),
   .tuningless_en_o(tuningless_en_o), .irq_o(irq_o));
